// File: serial_dac_pkg.sv
package serial_dac_pkg;

  // Frame lengths of the two resolution variants
  localparam int unsigned FRAME_BITS_RES16 = 24;
  localparam int unsigned FRAME_BITS_RES14 = 16;

  // Converter register value after reset: zero scale
  localparam logic [23:0] ZERO_SCALE = 24'h000000;

  // Fastest serial clock the far end may use, in Hz
  localparam int unsigned LINK_CLK_MAX_HZ = 50000000;

  // Own clock rate, in Hz
  localparam int unsigned SYS_CLK_HZ = 40000000;

  // The three serial lines, carried together
  typedef struct packed {
    logic frame_sel_b;
    logic ser_clk;
    logic ser_data;
  } serial_lines_s;

  // Idle level of the lines: frame high, link clock parked high
  localparam serial_lines_s LINES_IDLE = 3'b110;

  // Receive sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_HOLD = 2'b10
  } frame_state_e;

endpackage : serial_dac_pkg

// File: serial_dac_input_port.sv
`timescale 1ns/1ps
module serial_dac_input_port #(
  parameter int unsigned FRAME_BITS = serial_dac_pkg::FRAME_BITS_RES16
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic frame_sel_b_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  output logic [FRAME_BITS-1:0] analog_output_out,
  output logic update_out,
  output logic busy_out
);

  localparam int unsigned CNT_W = $clog2(FRAME_BITS + 1);
  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(FRAME_BITS - 1);

  // Only the two variant frame lengths are served; refuse others early
  if (FRAME_BITS != serial_dac_pkg::FRAME_BITS_RES16 &&
      FRAME_BITS != serial_dac_pkg::FRAME_BITS_RES14)
  begin : g_bad_frame_bits
    $error("FRAME_BITS must be 16 or 24");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  serial_dac_pkg::serial_lines_s pins_w;
  serial_dac_pkg::serial_lines_s meta_q;
  serial_dac_pkg::serial_lines_s sync_q;
  serial_dac_pkg::serial_lines_s last_q;

  assign pins_w.frame_sel_b = frame_sel_b_in;
  assign pins_w.ser_clk = ser_clk_in;
  assign pins_w.ser_data = ser_data_in;

  // Two stages, then a third for edge finding; meta_q feeds only sync_q
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_q <= serial_dac_pkg::LINES_IDLE;
      sync_q <= serial_dac_pkg::LINES_IDLE;
      last_q <= serial_dac_pkg::LINES_IDLE;
    end
    else
    begin
      meta_q <= pins_w;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge decode

  // Sampling at 40 MHz cannot follow a 50 MHz link; the bench runs slower
  wire sclk_fall_w = last_q.ser_clk & ~sync_q.ser_clk;
  wire frame_fall_w = last_q.frame_sel_b & ~sync_q.frame_sel_b;
  wire frame_rise_w = ~last_q.frame_sel_b & sync_q.frame_sel_b;
  wire frame_low_w = ~sync_q.frame_sel_b;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  serial_dac_pkg::frame_state_e state_q;
  serial_dac_pkg::frame_state_e state_d;
  logic [CNT_W-1:0] bit_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] word_q;
  logic update_q;
  logic written_q;

  wire in_shift_w = (state_q == serial_dac_pkg::ST_SHIFT);
  wire take_bit_w = in_shift_w & sclk_fall_w & frame_low_w;
  wire last_bit_w = take_bit_w & (bit_cnt_q == LAST_CNT);
  // Early rise: no final edge taken yet, so the frame is dropped
  wire abort_w = in_shift_w & frame_rise_w & ~last_bit_w;
  // Shift left so the first bit reaches the top position
  wire [FRAME_BITS-1:0] shift_next_w =
    {shift_q[FRAME_BITS-2:0], sync_q.ser_data};

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      serial_dac_pkg::ST_IDLE:
        if (frame_fall_w)
        begin
          state_d = serial_dac_pkg::ST_SHIFT;
        end
      serial_dac_pkg::ST_SHIFT:
        if (last_bit_w)
        begin
          state_d = serial_dac_pkg::ST_HOLD;
        end
        else if (abort_w)
        begin
          state_d = serial_dac_pkg::ST_IDLE;
        end
      serial_dac_pkg::ST_HOLD:
        if (frame_rise_w)
        begin
          state_d = serial_dac_pkg::ST_IDLE;
        end
      default:
        state_d = serial_dac_pkg::ST_IDLE;
    endcase
  end

  // State, bit count and shift register
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= serial_dac_pkg::ST_IDLE;
      bit_cnt_q <= '0;
      shift_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (frame_fall_w)
      begin
        bit_cnt_q <= '0;
      end
      else if (take_bit_w)
      begin
        bit_cnt_q <= bit_cnt_q + CNT_W'(1);
        shift_q <= shift_next_w;
      end
    end
  end

  // Converter register, loaded only by a completed frame
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      word_q <= serial_dac_pkg::ZERO_SCALE[FRAME_BITS-1:0];
      update_q <= 1'b0;
      written_q <= 1'b0;
    end
    else
    begin
      update_q <= last_bit_w;
      if (last_bit_w)
      begin
        word_q <= shift_next_w;
        written_q <= 1'b1;
      end
    end
  end

  assign analog_output_out = word_q;
  assign update_out = update_q;
  assign busy_out = in_shift_w;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_bit_taken;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    take_bit_w |=> shift_q[0] == $past(sync_q.ser_data) &&
      bit_cnt_q == $past(bit_cnt_q) + CNT_W'(1);
  endproperty
  a_bit_taken: assert property (p_bit_taken)
    else $error("Serial bit not shifted on clock fall");

  property p_frame_len;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    bit_cnt_q <= CNT_W'(FRAME_BITS);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("Bit count ran past the frame length");

  property p_frame_start;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (state_q == serial_dac_pkg::ST_IDLE) && frame_fall_w |=>
      in_shift_w && bit_cnt_q == '0;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("Frame select fall did not open a frame");

  property p_load;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    last_bit_w |=> update_out && analog_output_out == $past(shift_next_w)
      && state_q == serial_dac_pkg::ST_HOLD;
  endproperty
  a_load: assert property (p_load)
    else $error("Completed word not loaded");

  property p_abort;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    abort_w |=> state_q == serial_dac_pkg::ST_IDLE &&
      $stable(analog_output_out) && !update_out ##1 !update_out;
  endproperty
  a_abort: assert property (p_abort)
    else $error("Aborted frame changed the output");

  property p_zero_scale;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    !written_q |-> analog_output_out == '0 && !update_out;
  endproperty
  a_zero_scale: assert property (p_zero_scale)
    else $error("Output left zero scale before a full write");

  property p_msb_first;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    take_bit_w |=>
      shift_q[FRAME_BITS-1:1] == $past(shift_q[FRAME_BITS-2:0]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("Shift direction wrong");

  property p_update_cause;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    $changed(analog_output_out) |-> update_out && $past(bit_cnt_q) == LAST_CNT;
  endproperty
  a_update_cause: assert property (p_update_cause)
    else $error("Output changed without a final edge");

endmodule : serial_dac_input_port

// File: serial_ctrl_model.sv
`timescale 1ns/1ps
// Far-end controller: drives the three serial lines, link period 200 ns
module serial_ctrl_model (
  input wire logic sys_clk_in,
  output serial_dac_pkg::serial_lines_s lines_out
);
  // Idle lines: frame high, link clock parked high outside frames
  initial lines_out = '{frame_sel_b: 1'b1, ser_clk: 1'b1, ser_data: 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Half a link period is 4 system cycles (100 ns)
  task automatic wait_half();
    repeat (4) @(posedge sys_clk_in);
  endtask : wait_half

  // One frame, most significant first; too few bits makes an abort
  task automatic send(input logic [23:0] word, input int nbits);
    lines_out.frame_sel_b <= 1'b0;
    wait_half();
    for (int i = nbits - 1; i >= 0; i--)
    begin
      lines_out.ser_data <= word[i];
      wait_half();
      lines_out.ser_clk <= 1'b0;
      wait_half();
      lines_out.ser_clk <= 1'b1;
    end
    wait_half();
    lines_out.frame_sel_b <= 1'b1;
    // Released data line shows the inverse, never a stale bit
    lines_out.ser_data <= ~lines_out.ser_data;
    wait_half();
    wait_half();
  endtask : send
endmodule : serial_ctrl_model

// File: serial_dac_input_port_tb.sv
`timescale 1ns/1ps
module serial_dac_input_port_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  serial_dac_pkg::serial_lines_s lines;
  logic [23:0] out16;
  logic [15:0] out14;
  logic upd16, upd14, busy16, busy14;
  int n_upd16 = 0;
  int n_upd14 = 0;
  int n_mismatch = 0;
  int checks = 0;

  initial forever #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Both variants listen to the same lines, so one frame tests both lengths
  serial_ctrl_model u_serial_ctrl_model (
    .sys_clk_in(sys_clk),
    .lines_out(lines)
  );
  serial_dac_input_port u_serial_dac_input_port (
    .sys_clk_in(sys_clk),
    .rst_b_in(rst_b),
    .frame_sel_b_in(lines.frame_sel_b),
    .ser_clk_in(lines.ser_clk),
    .ser_data_in(lines.ser_data),
    .analog_output_out(out16),
    .update_out(upd16),
    .busy_out(busy16)
  );
  serial_dac_input_port #(
    .FRAME_BITS(serial_dac_pkg::FRAME_BITS_RES14)
  ) u_serial_dac_input_port_res14 (
    .sys_clk_in(sys_clk),
    .rst_b_in(rst_b),
    .frame_sel_b_in(lines.frame_sel_b),
    .ser_clk_in(lines.ser_clk),
    .ser_data_in(lines.ser_data),
    .analog_output_out(out14),
    .update_out(upd14),
    .busy_out(busy14)
  );

  // Count update pulses; a one-cycle pulse counts once
  always @(posedge sys_clk)
  begin
    if (upd16 === 1'b1) n_upd16++;
    if (upd14 === 1'b1) n_upd14++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // Send one frame, then judge both variants once the lines are idle
  task automatic frame_check(input logic [23:0] word, input int nbits,
                             input logic [23:0] e16, input logic [15:0] e14,
                             input int u16, input int u14);
    fork
      u_serial_ctrl_model.send(word, nbits);
      begin
        repeat (12) @(posedge sys_clk);
        check("busy_mid", {22'h0, busy16, busy14}, 24'h3);
      end
    join
    repeat (4) @(posedge sys_clk);
    check("out16", out16, e16);
    check("out14", {8'h00, out14}, {8'h00, e14});
    check("updates16", 24'(n_upd16), 24'(u16));
    check("updates14", 24'(n_upd14), 24'(u14));
    check("busy", {22'h0, busy16, busy14}, 24'h0);
  endtask : frame_check

  ////////////////////////////////////////////////////////////////////////////
  task automatic reset_values();
    check("out16", out16, serial_dac_pkg::ZERO_SCALE);
    check("out14", {8'h00, out14}, 24'h0);
  endtask : reset_values

  // Partial frame leaves zero scale in place
  task automatic abort_early();
    frame_check(24'h000155, 10, 24'h0, 16'h0, 0, 0);
  endtask : abort_early

  // Full long frame: short variant keeps its first 16 bits, ignores the rest
  task automatic full_long();
    frame_check(24'ha5c3f1, 24, 24'ha5c3f1, 16'ha5c3, 1, 1);
  endtask : full_long

  // Short frame aborts the long variant only
  task automatic full_short();
    frame_check(24'h003c5a, 16, 24'ha5c3f1, 16'h3c5a, 1, 2);
  endtask : full_short

  // Mid-run reset: back to zero scale, then a full write lands again
  task automatic reset_again();
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset_values();
    check("busy_rst", {22'h0, busy16, busy14}, 24'h0);
    frame_check(24'h0ff0a5, 24, 24'h0ff0a5, 16'h0ff0, 3, 4);
  endtask : reset_again

  // New frame right after: register follows again
  task automatic next_long();
    frame_check(24'h5a0ff0, 24, 24'h5a0ff0, 16'h5a0f, 2, 3);
  endtask : next_long

  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset_values();
    abort_early();
    full_long();
    full_short();
    next_long();
    reset_again();
    results();
  end

  // Watchdog: five frames take about 22 us
  initial
  begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule : serial_dac_input_port_tb
